/* File: logic/flash_seq_pkg.sv */
// constants and types shared by the flash write operation sequencer
package flash_seq_pkg;
	localparam int DW = 16;
	// register indices on the write port
	localparam logic [3:0] IDX_CTRL0 = 4'h0;
	localparam logic [3:0] IDX_SEC_LO = 4'h1;
	localparam logic [3:0] IDX_SEC_HI = 4'h2;
	localparam logic [3:0] IDX_ADDR_LO = 4'h3;
	localparam logic [3:0] IDX_ADDR_HI = 4'h4;
	localparam logic [3:0] IDX_D0_LO = 4'h5;
	localparam logic [3:0] IDX_D0_HI = 4'h6;
	localparam logic [3:0] IDX_D1_LO = 4'h7;
	localparam logic [3:0] IDX_D1_HI = 4'h8;
	localparam logic [3:0] IDX_ERR = 4'h9;
	localparam logic [3:0] IDX_TAU = 4'hA;
	// ctrl0_high bit positions
	localparam int B_GO = 15;
	localparam int B_SUSPEND_REQ = 14;
	localparam int B_WPG = 13;
	localparam int B_DWORD_PROG_SEL = 12;
	localparam int B_SER = 11;
	localparam int B_SPR = 8;
	localparam logic [15:0] SEL_MASK = 16'h3900;
	// word_select_addr_bit inside op_addr_low
	localparam int B_WSEL = 2;
	// error_reg and temp_unprotect_reg bits
	localparam int B_RESERR = 0;
	localparam int B_PROTERR = 1;
	localparam int B_TEMP_UNPROTECT_BIT = 0;
	// nonvolatile protection disable/re-enable register address
	localparam logic [31:0] NV_PROT_ADDR = 32'h0008DFBC;
	localparam logic [4:0] PERM_MAX = 5'h10;
	localparam logic [15:0] REG_RST = 16'h0000;
	localparam logic [31:0] ADDR_RST = 32'h00000000;
	localparam logic [63:0] DATA_RST = 64'h0000000000000000;
	localparam logic [4:0] CNT_RST = 5'h00;

	typedef enum logic [2:0] {
		CMD_NONE = 3'h0,
		CMD_WORD = 3'h1,
		CMD_DWORD = 3'h2,
		CMD_ERASE = 3'h3,
		CMD_PROT = 3'h4
	} cmd_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RUN = 3'b001,
		ST_SUSPW = 3'b011,
		ST_SUSPEND_REQ = 3'b010,
		ST_SPROG = 3'b110
	} state_t;
endpackage

/* File: logic/flash_write_op_sequencer.sv */
// flash write operation sequencer: select, load, start, suspend, resume
// How it works
// - select bit, then address/data, then start
// - clearing select before start cancels operation
// - 0x2000 selects 32-bit word program
// - 0x1000 selects 64-bit double word program
// - double word ignores word select address bit
// - 0x0800 selects erase of control1 sectors
// - 0x8000 starts the selected operation
// - 0x4000 suspends program or erase, no start
// - same select bit plus start resumes
// - sector bits read zero after erase completes
// - mismatched select at resume aborts, flags error
// - program allowed in erase suspend, bits low
// - program inside erase suspend not suspendable
// - 0x0100 selects set protection on address
// - permanent protection toggles limited to sixteen
// - control register writes are 16 bits
// - temp unprotect bit disables access protection
`timescale 1ns/100ps
module flash_write_op_sequencer
	import flash_seq_pkg::*;
(
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// register write port
	input wire logic i_reg_we,
	input wire logic [3:0] i_reg_idx,
	input wire logic [DW-1:0] i_reg_wdata,
	// register read-back
	output logic [DW-1:0] o_ctrl0_high,
	output logic [DW-1:0] o_erase_sector_sel_low,
	output logic [DW-1:0] o_erase_sector_sel_high,
	output logic [DW-1:0] o_error_reg,
	output logic o_access_unprot,
	output logic [4:0] o_perm_count,
	output logic o_suspended,
	// flash array engine
	input wire logic i_arr_done,
	input wire logic i_arr_suspend_req_ack,
	output logic o_arr_start,
	output cmd_t o_arr_cmd,
	output logic [31:0] o_arr_addr,
	output logic [63:0] o_arr_data,
	output logic o_arr_suspend,
	output logic o_arr_resume,
	output logic o_arr_abort
);
	state_t state_q, state_d;
	logic [DW-1:0] ctrl0_q, sec_lo_q, sec_hi_q, err_q, saved_q;
	logic [31:0] addr_q;
	logic [63:0] data_q;
	logic temp_unprotect_bit_q, suspend_req_q;
	logic [4:0] perm_q;
	cmd_t op_q;
	function automatic logic onehot(input logic [DW-1:0] c);
		logic [DW-1:0] s;
		s = c & SEL_MASK;
		return (s != REG_RST) && ((s & (s - 16'h0001)) == REG_RST);
	endfunction
	// first selection bit wins; onehot() guards against several
	function automatic cmd_t sel_cmd(input logic [DW-1:0] c);
		return c[B_WPG] ? CMD_WORD : c[B_DWORD_PROG_SEL] ? CMD_DWORD :
			c[B_SER] ? CMD_ERASE : c[B_SPR] ? CMD_PROT : CMD_NONE;
	endfunction
	logic wr_ctrl, go_wr, suspend_req_wr, perm_op, prot_bad, start_ok, suspend_req_ok;
	logic match, resume_ok, sprog_ok, resume_bad, done_run;
	logic [DW-1:0] sel;
	cmd_t cur_cmd;

	assign wr_ctrl = i_reg_we && (i_reg_idx == IDX_CTRL0);
	// a write carrying the start bit only launches; selection stays as is
	assign go_wr = wr_ctrl && i_reg_wdata[B_GO];
	assign suspend_req_wr = wr_ctrl && !i_reg_wdata[B_GO] && i_reg_wdata[B_SUSPEND_REQ];
	assign sel = ctrl0_q & SEL_MASK;
	assign cur_cmd = sel_cmd(ctrl0_q);
	// cleared data bits on the nv protect register mean a permanent toggle
	assign perm_op = (cur_cmd == CMD_PROT) && (addr_q == NV_PROT_ADDR) &&
		(data_q[31:0] != 32'hFFFFFFFF);
	assign prot_bad = perm_op && (!temp_unprotect_bit_q || (perm_q == PERM_MAX));
	assign start_ok = (state_q == ST_IDLE) && go_wr && onehot(ctrl0_q) &&
		!ctrl0_q[B_SUSPEND_REQ] && !prot_bad;
	assign suspend_req_ok = (state_q == ST_RUN) && suspend_req_wr && (op_q != CMD_PROT);
	assign match = (sel == saved_q);
	assign resume_ok = (state_q == ST_SUSPEND_REQ) && go_wr && match;
	// program of another sector in erase suspend
	assign sprog_ok = (state_q == ST_SUSPEND_REQ) && go_wr && !match &&
		!ctrl0_q[B_SUSPEND_REQ] && !ctrl0_q[B_SER] && saved_q[B_SER] &&
		onehot(ctrl0_q) && (ctrl0_q[B_WPG] || ctrl0_q[B_DWORD_PROG_SEL]);
	assign resume_bad = (state_q == ST_SUSPEND_REQ) && go_wr && !match && !sprog_ok;
	assign done_run = i_arr_done &&
		((state_q == ST_RUN) || (state_q == ST_SUSPW));

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: if (start_ok) begin
				state_d = ST_RUN;
			end
			ST_RUN: if (i_arr_done) begin
				state_d = ST_IDLE;
			end else if (suspend_req_ok) begin
				state_d = ST_SUSPW;
			end
			// completion can overtake the suspend request
			ST_SUSPW: if (i_arr_done) begin
				state_d = ST_IDLE;
			end else if (i_arr_suspend_req_ack) begin
				state_d = ST_SUSPEND_REQ;
			end
			ST_SUSPEND_REQ: if (resume_ok) begin
				state_d = ST_RUN;
			end else if (sprog_ok) begin
				state_d = ST_SPROG;
			end else if (resume_bad) begin
				state_d = ST_IDLE;
			end
			ST_SPROG: if (i_arr_done) begin
				state_d = ST_SUSPEND_REQ;
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= ST_IDLE;
			suspend_req_q <= 1'b0;
		end else begin
			state_q <= state_d;
			suspend_req_q <= (state_d == ST_SUSPEND_REQ) || (state_d == ST_SPROG);
		end
	end

	// control register 0: selection, suspend and busy bits
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl0_q <= REG_RST;
		end else if (start_ok || resume_ok) begin
			ctrl0_q[B_GO] <= 1'b1;
			ctrl0_q[B_SUSPEND_REQ] <= 1'b0;
		end else if (sprog_ok) begin
			ctrl0_q[B_GO] <= 1'b1;
			ctrl0_q[B_SER] <= 1'b0;
			ctrl0_q[B_SUSPEND_REQ] <= 1'b0;
		end else if (done_run || resume_bad) begin
			ctrl0_q <= REG_RST;
		end else if (state_q == ST_SPROG && i_arr_done) begin
			ctrl0_q[B_GO] <= 1'b0;
			ctrl0_q[B_WPG] <= 1'b0;
			ctrl0_q[B_DWORD_PROG_SEL] <= 1'b0;
		end else if (state_q == ST_SUSPW && i_arr_suspend_req_ack) begin
			ctrl0_q[B_GO] <= 1'b0;
		end else if (suspend_req_ok) begin
			ctrl0_q[B_SUSPEND_REQ] <= 1'b1;
		end else if (wr_ctrl && !i_reg_wdata[B_GO] &&
			(state_q == ST_IDLE || state_q == ST_SUSPEND_REQ)) begin
			ctrl0_q[B_SUSPEND_REQ] <= i_reg_wdata[B_SUSPEND_REQ];
			ctrl0_q[B_WPG] <= i_reg_wdata[B_WPG];
			ctrl0_q[B_DWORD_PROG_SEL] <= i_reg_wdata[B_DWORD_PROG_SEL];
			ctrl0_q[B_SER] <= i_reg_wdata[B_SER];
			ctrl0_q[B_SPR] <= i_reg_wdata[B_SPR];
		end
	end

	// erase sector selection, frozen while an operation runs
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sec_lo_q <= REG_RST;
			sec_hi_q <= REG_RST;
		end else if (done_run && op_q == CMD_ERASE) begin
			sec_lo_q <= REG_RST;
			sec_hi_q <= REG_RST;
		end else if (i_reg_we && (state_q == ST_IDLE)) begin
			if (i_reg_idx == IDX_SEC_LO) begin
				sec_lo_q <= i_reg_wdata;
			end else if (i_reg_idx == IDX_SEC_HI) begin
				sec_hi_q <= i_reg_wdata;
			end
		end
	end

	// address and data staging; also loadable during erase suspend
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			addr_q <= ADDR_RST;
			data_q <= DATA_RST;
		end else if (i_reg_we &&
			(state_q == ST_IDLE || state_q == ST_SUSPEND_REQ)) begin
			if (i_reg_idx == IDX_ADDR_LO) begin
				addr_q[15:0] <= i_reg_wdata;
			end else if (i_reg_idx == IDX_ADDR_HI) begin
				addr_q[31:16] <= i_reg_wdata;
			end else if (i_reg_idx == IDX_D0_LO) begin
				data_q[15:0] <= i_reg_wdata;
			end else if (i_reg_idx == IDX_D0_HI) begin
				data_q[31:16] <= i_reg_wdata;
			end else if (i_reg_idx == IDX_D1_LO) begin
				data_q[47:32] <= i_reg_wdata;
			end else if (i_reg_idx == IDX_D1_HI) begin
				data_q[63:48] <= i_reg_wdata;
			end
		end
	end

	// launch to the array engine
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_arr_start <= 1'b0;
			o_arr_cmd <= CMD_NONE;
			o_arr_addr <= ADDR_RST;
			o_arr_data <= DATA_RST;
			op_q <= CMD_NONE;
		end else begin
			o_arr_start <= start_ok || sprog_ok;
			if (start_ok || sprog_ok) begin
				o_arr_cmd <= cur_cmd;
				op_q <= cur_cmd;
				o_arr_addr <= addr_q;
				o_arr_data <= data_q;
				if (cur_cmd == CMD_DWORD) begin
					o_arr_addr[B_WSEL] <= 1'b0;
				end
			end else if (resume_ok || (state_q == ST_SPROG && i_arr_done)) begin
				op_q <= sel_cmd(saved_q);
			end
		end
	end

	// suspend, resume and abort strobes
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_arr_suspend <= 1'b0;
			o_arr_resume <= 1'b0;
			o_arr_abort <= 1'b0;
			saved_q <= REG_RST;
		end else begin
			o_arr_suspend <= suspend_req_ok;
			o_arr_resume <= resume_ok;
			o_arr_abort <= resume_bad;
			if (suspend_req_ok) begin
				saved_q <= sel;
			end
		end
	end

	// error flags: hardware set wins over a software clear
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			err_q <= REG_RST;
		end else begin
			if (i_reg_we && i_reg_idx == IDX_ERR) begin
				err_q[B_RESERR] <= i_reg_wdata[B_RESERR] & err_q[B_RESERR];
				err_q[B_PROTERR] <= i_reg_wdata[B_PROTERR] & err_q[B_PROTERR];
			end
			if (resume_bad) begin
				err_q[B_RESERR] <= 1'b1;
			end
			if (state_q == ST_IDLE && go_wr && onehot(ctrl0_q) && prot_bad) begin
				err_q[B_PROTERR] <= 1'b1;
			end
		end
	end

	// temporary unprotection and permanent toggle count
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			temp_unprotect_bit_q <= 1'b0;
			perm_q <= CNT_RST;
		end else begin
			if (i_reg_we && i_reg_idx == IDX_TAU) begin
				temp_unprotect_bit_q <= i_reg_wdata[B_TEMP_UNPROTECT_BIT];
			end
			if (start_ok && perm_op) begin
				perm_q <= perm_q + 5'h01;
			end
		end
	end

	assign o_ctrl0_high = ctrl0_q;
	assign o_erase_sector_sel_low = sec_lo_q;
	assign o_erase_sector_sel_high = sec_hi_q;
	assign o_error_reg = err_q;
	assign o_access_unprot = temp_unprotect_bit_q;
	assign o_perm_count = perm_q;
	assign o_suspended = suspend_req_q;

	default clocking cb_sys @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);
	property p_start;
		start_ok |=> o_arr_start && (o_arr_cmd == $past(cur_cmd));
	endproperty
	a_start: assert property (p_start) else $error("start not issued");
	property p_nosel;
		(state_q == ST_IDLE) && go_wr && (sel == REG_RST) |=>
			!o_arr_start && (state_q == ST_IDLE);
	endproperty
	a_nosel: assert property (p_nosel) else $error("empty start ran");
	property p_align;
		o_arr_start && (o_arr_cmd == CMD_DWORD) |-> !o_arr_addr[B_WSEL];
	endproperty
	a_align: assert property (p_align) else $error("dword misaligned");
	property p_erase_clr;
		done_run && (op_q == CMD_ERASE) |=>
			(sec_lo_q == REG_RST) && (sec_hi_q == REG_RST);
	endproperty
	a_erase_clr: assert property (p_erase_clr) else $error("sectors kept");
	property p_suspend_req;
		suspend_req_ok && !i_arr_done |=> o_arr_suspend ##1 (state_q != ST_RUN);
	endproperty
	a_suspend_req: assert property (p_suspend_req) else $error("suspend lost");
	property p_nosusp;
		(state_q == ST_SPROG) |=> !o_arr_suspend;
	endproperty
	a_nosusp: assert property (p_nosusp) else $error("sprog suspended");
	property p_sprog_bits;
		(state_q == ST_SPROG) |-> !o_ctrl0_high[B_SER] && !o_ctrl0_high[B_SUSPEND_REQ];
	endproperty
	a_sprog_bits: assert property (p_sprog_bits) else $error("bits high");
	property p_resbad;
		resume_bad |=> o_error_reg[B_RESERR] && o_arr_abort &&
			(state_q == ST_IDLE);
	endproperty
	a_resbad: assert property (p_resbad) else $error("no resume error");
	property p_resume;
		resume_ok |=> o_arr_resume && (state_q == ST_RUN) && !o_arr_start;
	endproperty
	a_resume: assert property (p_resume) else $error("resume lost");
	property p_perm;
		(perm_q == PERM_MAX) |=> (perm_q == PERM_MAX);
	endproperty
	a_perm: assert property (p_perm) else $error("toggle over limit");
	c_erase: cover property (done_run && op_q == CMD_ERASE);
	c_sprog: cover property (sprog_ok);
	c_resume: cover property (resume_ok);
	c_resbad: cover property (resume_bad);
endmodule

/* File: testbench/tb_flash_write_op_sequencer.sv */
// self-checking bench for the flash write operation sequencer
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
	$display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb_flash_write_op_sequencer import flash_seq_pkg::*;;
	typedef struct {
		logic [1:0] kind;
		cmd_t cmd;
		logic full;
		logic [31:0] addr;
		logic [63:0] data;
	} note_t;
	logic i_clk_sys = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_reg_we = 1'b0;
	logic i_arr_done = 1'b0;
	logic i_arr_suspend_req_ack = 1'b0;
	logic [3:0] i_reg_idx = 4'h0;
	logic [15:0] i_reg_wdata = 16'h0000;
	logic [15:0] o_ctrl0_high, o_erase_sector_sel_low, o_erase_sector_sel_high;
	logic [15:0] o_error_reg;
	logic o_access_unprot, o_suspended, o_arr_start, o_arr_suspend;
	logic o_arr_resume, o_arr_abort;
	logic [4:0] o_perm_count;
	cmd_t o_arr_cmd;
	logic [31:0] o_arr_addr;
	logic [63:0] o_arr_data;
	int err_total = 0;
	int checks = 0;
	int seed = 83472;
	int i, k;
	logic [15:0] m [0:15];
	note_t q[$];
	note_t n;
	logic [1:0] ks;

	flash_write_op_sequencer u_dut (.i_clk_sys, .i_rst_n, .i_reg_we,
		.i_reg_idx, .i_reg_wdata, .o_ctrl0_high, .o_erase_sector_sel_low,
		.o_erase_sector_sel_high, .o_error_reg, .o_access_unprot,
		.o_perm_count, .o_suspended, .i_arr_done, .i_arr_suspend_req_ack,
		.o_arr_start, .o_arr_cmd, .o_arr_addr, .o_arr_data, .o_arr_suspend,
		.o_arr_resume, .o_arr_abort);

	always #5 i_clk_sys = ~i_clk_sys;

	task test_done;
		begin
			$display("checks %0d err_total %0d", checks, err_total);
			if (err_total == 0 && checks > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask

	// bench stands in for RAM code
	// every register write is one 16-bit word
	task wr(input logic [3:0] idx, input logic [15:0] d);
		begin
			@(negedge i_clk_sys);
			i_reg_we = 1'b1;
			i_reg_idx = idx;
			i_reg_wdata = d;
			m[idx] = d;
			@(negedge i_clk_sys);
			i_reg_we = 1'b0;
		end
	endtask

	task pulse(input bit ack);
		begin
			@(negedge i_clk_sys);
			if (ack)
				i_arr_suspend_req_ack = 1'b1;
			else
				i_arr_done = 1'b1;
			@(negedge i_clk_sys);
			i_arr_suspend_req_ack = 1'b0;
			i_arr_done = 1'b0;
		end
	endtask

	// kinds: 0 start, 1 suspend, 2 resume, 3 abort
	task expect_op(input logic [1:0] kind, input cmd_t c, input logic full);
		note_t x;
		begin
			x.kind = kind;
			x.cmd = c;
			x.full = full;
			x.addr = {m[4], m[3]};
			x.data = {m[8], m[7], m[6], m[5]};
			if (c == CMD_DWORD)
				x.addr[B_WSEL] = 1'b0;
			q.push_back(x);
		end
	endtask

	task load;
		begin
			for (k = 3; k < 9; k++)
				wr(k[3:0], 16'($random(seed)));
		end
	endtask

	task prog(input cmd_t c, input logic [15:0] sel);
		begin
			wr(IDX_CTRL0, sel);
			`CHK("ctrl0 select", sel, o_ctrl0_high)
			load();
			// force the ignored word-select bit high for double words
			if (c == CMD_DWORD)
				wr(IDX_ADDR_LO, m[3] | 16'h0004);
			expect_op(2'h0, c, 1'b1);
			wr(IDX_CTRL0, 16'h8000);
			`CHK("busy", 1'b1, o_ctrl0_high[B_GO])
		end
	endtask

	task erase_suspend_req(input logic [15:0] sec);
		begin
			wr(IDX_CTRL0, 16'h0800);
			wr(IDX_SEC_LO, sec);
			wr(IDX_SEC_HI, 16'h0000);
			`CHK("sector low", sec, o_erase_sector_sel_low)
			expect_op(2'h0, CMD_ERASE, 1'b0);
			wr(IDX_CTRL0, 16'h8000);
			expect_op(2'h1, CMD_NONE, 1'b0);
			wr(IDX_CTRL0, 16'h4000);
			pulse(1'b1);
			`CHK("suspended", 1'b1, o_suspended)
			`CHK("busy", 1'b0, o_ctrl0_high[B_GO])
		end
	endtask

	task tend(input string nm);
		$display("test %s done", nm);
	endtask

	// watcher: every pulse from the sequencer must match the oldest note
	always @(negedge i_clk_sys) begin
		if (i_rst_n === 1'b1 && (o_arr_start === 1'b1 ||
			o_arr_suspend === 1'b1 || o_arr_resume === 1'b1 ||
			o_arr_abort === 1'b1)) begin
			ks = o_arr_start ? 2'h0 : o_arr_suspend ? 2'h1 :
				o_arr_resume ? 2'h2 : 2'h3;
			if (q.size() == 0) begin
				`CHK("unexpected pulse", 1'b0, 1'b1)
			end else begin
				n = q.pop_front();
				`CHK("pulse kind", n.kind, ks)
				if (ks == 2'h0)
					`CHK("cmd", n.cmd, o_arr_cmd)
				if (ks == 2'h0 && n.full) begin
					`CHK("addr", n.addr, o_arr_addr)
					`CHK("data", n.data, o_arr_data)
				end
			end
		end
	end

	initial begin
		#200000;
		err_total++;
		test_done();
	end

	initial begin
		for (i = 0; i < 16; i++)
			m[i] = 16'h0000;
		repeat (4) @(negedge i_clk_sys);
		i_rst_n = 1'b1;
		// back-to-back word and double-word programs with random payloads
		for (i = 0; i < 4; i++) begin
			prog(CMD_WORD, 16'h2000);
			pulse(1'b0);
			`CHK("ctrl0 done", 16'h0000, o_ctrl0_high)
			prog(CMD_DWORD, 16'h1000);
			pulse(1'b0);
			`CHK("ctrl0 done", 16'h0000, o_ctrl0_high)
		end
		// suspend and resume a word program
		prog(CMD_WORD, 16'h2000);
		expect_op(2'h1, CMD_NONE, 1'b0);
		wr(IDX_CTRL0, 16'h4000);
		pulse(1'b1);
		`CHK("word suspended", 1'b1, o_suspended)
		expect_op(2'h2, CMD_NONE, 1'b0);
		wr(IDX_CTRL0, 16'h8000);
		pulse(1'b0);
		`CHK("ctrl0 done", 16'h0000, o_ctrl0_high)
		tend("program");
		wr(IDX_CTRL0, 16'h2000);
		wr(IDX_CTRL0, 16'h0000);
		wr(IDX_CTRL0, 16'h8000);
		repeat (2) @(negedge i_clk_sys);
		`CHK("ctrl0 cancel", 16'h0000, o_ctrl0_high)
		tend("cancel");
		erase_suspend_req(16'h0003);
		wr(IDX_CTRL0, 16'h0000);
		wr(IDX_CTRL0, 16'h2000);
		load();
		expect_op(2'h0, CMD_WORD, 1'b1);
		wr(IDX_CTRL0, 16'h8000);
		`CHK("erase bit", 1'b0, o_ctrl0_high[B_SER])
		`CHK("suspend bit", 1'b0, o_ctrl0_high[B_SUSPEND_REQ])
		// a suspend here must be ignored: no note queued
		wr(IDX_CTRL0, 16'h4000);
		pulse(1'b0);
		`CHK("back in suspend", 1'b1, o_suspended)
		wr(IDX_CTRL0, 16'h0800);
		expect_op(2'h2, CMD_NONE, 1'b0);
		wr(IDX_CTRL0, 16'h8000);
		`CHK("resumed busy", 1'b1, o_ctrl0_high[B_GO])
		pulse(1'b0);
		`CHK("sector low", 16'h0000, o_erase_sector_sel_low)
		`CHK("sector high", 16'h0000, o_erase_sector_sel_high)
		`CHK("suspended", 1'b0, o_suspended)
		tend("suspend");
		erase_suspend_req(16'h0001);
		wr(IDX_CTRL0, 16'h0100);
		expect_op(2'h3, CMD_NONE, 1'b0);
		wr(IDX_CTRL0, 16'h8000);
		`CHK("resume error", 1'b1, o_error_reg[B_RESERR])
		`CHK("ctrl0 abort", 16'h0000, o_ctrl0_high)
		wr(IDX_ERR, 16'h0000);
		`CHK("error clear", 16'h0000, o_error_reg)
		tend("mismatch");
		// permanent toggle while still protected is refused
		wr(IDX_CTRL0, 16'h0100);
		wr(IDX_ADDR_LO, NV_PROT_ADDR[15:0]);
		wr(IDX_ADDR_HI, NV_PROT_ADDR[31:16]);
		wr(IDX_D0_LO, 16'hFFFE);
		wr(IDX_CTRL0, 16'h8000);
		`CHK("protect refused", 1'b1, o_error_reg[B_PROTERR])
		wr(IDX_ERR, 16'h0000);
		wr(IDX_TAU, 16'h0001);
		`CHK("unprotected", 1'b1, o_access_unprot)
		for (i = 0; i < 16; i++) begin
			wr(IDX_CTRL0, 16'h0100);
			expect_op(2'h0, CMD_PROT, 1'b1);
			wr(IDX_CTRL0, 16'h8000);
			pulse(1'b0);
		end
		`CHK("toggle count", PERM_MAX, o_perm_count)
		wr(IDX_CTRL0, 16'h0100);
		wr(IDX_CTRL0, 16'h8000);
		`CHK("seventeenth", 1'b1, o_error_reg[B_PROTERR])
		wr(IDX_TAU, 16'h0000);
		`CHK("protected", 1'b0, o_access_unprot)
		tend("protect");
		wr(IDX_TAU, 16'h0001);
		@(negedge i_clk_sys);
		i_rst_n = 1'b0;
		@(negedge i_clk_sys);
		`CHK("reset unprot", 1'b0, o_access_unprot)
		`CHK("reset count", CNT_RST, o_perm_count)
		i_rst_n = 1'b1;
		tend("reset");
		for (i = 0; i < 20 && q.size() > 0; i++)
			@(negedge i_clk_sys);
		`CHK("notes left", 0, q.size())
		test_done();
	end
endmodule
